// ===== fcr_defs.vh
// Constants for the fan control configuration and runtime register bank
// Operation
// - Runtime block 16-byte aligned, low four bits select
// - Base low byte bits 3-0 read zero
// - Base address bytes at 60h/61h, reset zero
// - Fan control registers decoded at 00h-03h
// - Fan monitor registers decoded at 06h-0Bh
// - Activate at 30h, read/write, resets inactive
// - Inactive device blocks runtime register access
// - Interrupt select at 70h, read/write, reset zero
// - Interrupt kind 71h: only bit 1 writable
// - 74h and 75h always read 04h
// - Config bits 2 and 5 enable monitors
// - Config bits 3 and 6 enable controls
// - Config bits 4 and 7 enable invert
// - Bit 0 with inactive device floats pins
// - Fan config resets zero, bit 1 reserved
`ifndef FCR_DEFS_VH
`define FCR_DEFS_VH

// Bus address layout: bits 19-18 pick the space
`define FCR_ADDR_W 20
`define FCR_SPACE_CFG 2'h0
`define FCR_SPACE_IO 2'h1
`define FCR_RESP_OKAY 2'h0
`define FCR_RESP_DECERR 2'h3

// Configuration indices (byte address is four times the index)
`define FCR_IDX_ACTIVATE 8'h30
`define FCR_IDX_BASE_HI 8'h60
`define FCR_IDX_BASE_LO 8'h61
`define FCR_IDX_IRQ_SEL 8'h70
`define FCR_IDX_IRQ_KIND 8'h71
`define FCR_IDX_DMA_A 8'h74
`define FCR_IDX_DMA_B 8'h75
`define FCR_IDX_FAN_CFG 8'hF0

// Runtime offsets within the 16-byte block (byte address four times)
`define FCR_OFF_PRESCALE0 4'h0
`define FCR_OFF_DUTY0 4'h1
`define FCR_OFF_PRESCALE1 4'h2
`define FCR_OFF_DUTY1 4'h3
`define FCR_OFF_THRESH0 4'h6
`define FCR_OFF_SPEED0 4'h7
`define FCR_OFF_CTRL0 4'h8
`define FCR_OFF_THRESH1 4'h9
`define FCR_OFF_SPEED1 4'hA
`define FCR_OFF_CTRL1 4'hB

// Reset values and write masks
`define FCR_RST_ZERO 8'h00
`define FCR_RST_IRQ_KIND 8'h03
`define FCR_IRQ_KIND_WMASK 8'h02
`define FCR_DMA_NONE 8'h04
`define FCR_BASE_LO_WMASK 8'hF0
`define FCR_FAN_CFG_WMASK 8'hFD
`define FCR_MON_CS_WMASK 8'hF0

// Fan configuration field positions
`define FCR_CFG_FLOAT 0
`define FCR_CFG_MON0 2
`define FCR_CFG_CTL0 3
`define FCR_CFG_INV0 4
`define FCR_CFG_MON1 5
`define FCR_CFG_CTL1 6
`define FCR_CFG_INV1 7

`endif

// ===== fcr_fan_config_regs.v
// Fan control logical device: configuration space, runtime registers, AXI4-Lite slave
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "fcr_defs.vh"

module fcr_fan_config_regs (
	input wire clock,
	input wire arst_n,
	// AXI4-Lite slave
	input wire [`FCR_ADDR_W-1:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`FCR_ADDR_W-1:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	// Monitor unit state shown to software
	input wire [7:0] mon0Speed,
	input wire [7:0] mon1Speed,
	input wire [3:0] mon0Status,
	input wire [3:0] mon1Status,
	// Settings driven to the fan units
	output wire [7:0] fan0Prescale,
	output wire [7:0] fan0Duty,
	output wire [7:0] fan1Prescale,
	output wire [7:0] fan1Duty,
	output wire [7:0] mon0Threshold,
	output wire [7:0] mon1Threshold,
	output wire [3:0] mon0Control,
	output wire [3:0] mon1Control,
	output wire mon0Enable,
	output wire mon1Enable,
	output wire ctl0Enable,
	output wire ctl1Enable,
	output wire inv0Enable,
	output wire inv1Enable,
	output wire deviceActive,
	output wire [7:0] irqSelect,
	output wire irqKindBit,
	output wire pinsFloat
);

	// Bus handshake state
	reg awReadyQ;
	reg wReadyQ;
	reg bValidQ;
	reg [1:0] bRespQ;
	reg arReadyQ;
	reg rValidQ;
	reg [31:0] rDataQ;
	reg [1:0] rRespQ;
	reg [`FCR_ADDR_W-1:0] awAddrQ;
	reg [7:0] wDataQ;
	reg wLaneQ;

	// Configuration registers
	reg activeQ;
	reg [7:0] baseHiQ;
	reg [7:0] baseLoQ;
	reg [7:0] irqSelQ;
	reg [7:0] irqKindQ;
	reg [7:0] fanCfgQ;
	reg pinsFloatQ;

	// Runtime registers, one entry per channel
	reg [7:0] prescaleQ [0:1];
	reg [7:0] dutyQ [0:1];
	reg [7:0] threshQ [0:1];
	reg [7:0] ctrlQ [0:1];

	// Combinational decode
	wire wrGo;
	wire wrCfg;
	wire wrIo;
	wire [7:0] wrIdx;
	wire [3:0] wrOff;
	wire [7:0] wrData;
	wire [3:0] rdOff;
	reg [7:0] rdByte;
	reg rdOk;

	// Protection codes, strobes 3-1 and data lanes 3-1 are not used:
	// every register is one byte carried in lane 0

	// True when the address lies in the configuration space
	function cfgSpace;
		input [`FCR_ADDR_W-1:0] addr;
		begin
			cfgSpace = (addr[19:18] == `FCR_SPACE_CFG) && (addr[17:10] == 8'h00);
		end
	endfunction

	// True when the address hits the active runtime block
	function ioHit;
		input [`FCR_ADDR_W-1:0] addr;
		input [7:0] hi;
		input [7:0] lo;
		input act;
		begin
			ioHit = (addr[19:18] == `FCR_SPACE_IO) && (addr[17:6] == {hi, lo[7:4]})
				&& act;
		end
	endfunction

	// Write is performed once both address and data are held
	assign wrGo = !awReadyQ && !wReadyQ && !bValidQ;
	assign wrCfg = cfgSpace(awAddrQ);
	assign wrIo = ioHit(awAddrQ, baseHiQ, baseLoQ, activeQ);
	assign wrIdx = awAddrQ[9:2];
	assign wrOff = awAddrQ[5:2];
	assign wrData = wDataQ;
	assign rdOff = s_axi_araddr[5:2];

	// Write address and data channels, taken in either order; response follows both
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			awReadyQ <= 1'b1;
			wReadyQ <= 1'b1;
			bValidQ <= 1'b0;
			bRespQ <= `FCR_RESP_OKAY;
			awAddrQ <= {`FCR_ADDR_W{1'b0}};
			wDataQ <= 8'h00;
			wLaneQ <= 1'b0;
		end else begin
			// Address channel
			if (awReadyQ && s_axi_awvalid) begin
				awReadyQ <= 1'b0;
				awAddrQ <= s_axi_awaddr;
			end
			// Data channel
			if (wReadyQ && s_axi_wvalid) begin
				wReadyQ <= 1'b0;
				wDataQ <= s_axi_wdata[7:0];
				wLaneQ <= s_axi_wstrb[0];
			end
			// Response once address and data are both held
			if (wrGo) begin
				bValidQ <= 1'b1;
				bRespQ <= (wrCfg || wrIo) ? `FCR_RESP_OKAY : `FCR_RESP_DECERR;
			end
			// Response taken: both channels open again
			if (bValidQ && s_axi_bready) begin
				bValidQ <= 1'b0;
				awReadyQ <= 1'b1;
				wReadyQ <= 1'b1;
			end
		end
	end

	// Configuration space writes
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			activeQ <= 1'b0;
			baseHiQ <= `FCR_RST_ZERO;
			baseLoQ <= `FCR_RST_ZERO;
			irqSelQ <= `FCR_RST_ZERO;
			irqKindQ <= `FCR_RST_IRQ_KIND;
			fanCfgQ <= `FCR_RST_ZERO;
		end else if (wrGo && wrCfg && wLaneQ) begin
			case (wrIdx)
				`FCR_IDX_ACTIVATE: begin
					activeQ <= wrData[0];
				end
				`FCR_IDX_BASE_HI: begin
					baseHiQ <= wrData;
				end
				`FCR_IDX_BASE_LO: begin
					baseLoQ <= wrData & `FCR_BASE_LO_WMASK;
				end
				`FCR_IDX_IRQ_SEL: begin
					irqSelQ <= wrData;
				end
				`FCR_IDX_IRQ_KIND: begin
					irqKindQ <= (irqKindQ & ~`FCR_IRQ_KIND_WMASK)
						| (wrData & `FCR_IRQ_KIND_WMASK);
				end
				`FCR_IDX_FAN_CFG: begin
					fanCfgQ <= wrData & `FCR_FAN_CFG_WMASK;
				end
				`FCR_IDX_DMA_A, `FCR_IDX_DMA_B: begin
					// Fixed no-DMA report: the write is dropped
					fanCfgQ <= fanCfgQ;
				end
				default: begin
					// Unused index: nothing changes
					fanCfgQ <= fanCfgQ;
				end
			endcase
		end
	end

	// Output float when the option is set and the device is inactive
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pinsFloatQ <= 1'b0;
		end else begin
			pinsFloatQ <= fanCfgQ[`FCR_CFG_FLOAT] && !activeQ;
		end
	end

	// Per-channel runtime registers
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : gChan
			wire [3:0] offPre;
			wire [3:0] offDuty;
			wire [3:0] offThr;
			wire [3:0] offCtl;
			assign offPre = (ch == 0) ? `FCR_OFF_PRESCALE0 : `FCR_OFF_PRESCALE1;
			assign offDuty = (ch == 0) ? `FCR_OFF_DUTY0 : `FCR_OFF_DUTY1;
			assign offThr = (ch == 0) ? `FCR_OFF_THRESH0 : `FCR_OFF_THRESH1;
			assign offCtl = (ch == 0) ? `FCR_OFF_CTRL0 : `FCR_OFF_CTRL1;

			// Writes at unused offsets match none of these and change nothing
			always @(posedge clock or negedge arst_n) begin
				if (!arst_n) begin
					prescaleQ[ch] <= `FCR_RST_ZERO;
					dutyQ[ch] <= `FCR_RST_ZERO;
					threshQ[ch] <= `FCR_RST_ZERO;
					ctrlQ[ch] <= `FCR_RST_ZERO;
				end else if (wrGo && wrIo && wLaneQ) begin
					if (wrOff == offPre) begin
						prescaleQ[ch] <= wrData;
					end
					if (wrOff == offDuty) begin
						dutyQ[ch] <= wrData;
					end
					if (wrOff == offThr) begin
						threshQ[ch] <= wrData;
					end
					if (wrOff == offCtl) begin
						ctrlQ[ch] <= wrData & `FCR_MON_CS_WMASK;
					end
				end
			end
		end
	endgenerate

	// Read data selection for the address offered on the read channel
	always @* begin
		rdByte = 8'h00;
		rdOk = 1'b0;
		// Configuration space, picked by index
		if (cfgSpace(s_axi_araddr)) begin
			rdOk = 1'b1;
			case (s_axi_araddr[9:2])
				`FCR_IDX_ACTIVATE: rdByte = {7'h00, activeQ};
				`FCR_IDX_BASE_HI: rdByte = baseHiQ;
				`FCR_IDX_BASE_LO: rdByte = baseLoQ & `FCR_BASE_LO_WMASK;
				`FCR_IDX_IRQ_SEL: rdByte = irqSelQ;
				`FCR_IDX_IRQ_KIND: rdByte = irqKindQ;
				`FCR_IDX_DMA_A: rdByte = `FCR_DMA_NONE;
				`FCR_IDX_DMA_B: rdByte = `FCR_DMA_NONE;
				`FCR_IDX_FAN_CFG: rdByte = fanCfgQ;
				default: rdByte = 8'h00;
			endcase
		end else if (ioHit(s_axi_araddr, baseHiQ, baseLoQ, activeQ)) begin
			// Runtime block, reachable only while active
			rdOk = 1'b1;
			case (rdOff)
				`FCR_OFF_PRESCALE0: rdByte = prescaleQ[0];
				`FCR_OFF_DUTY0: rdByte = dutyQ[0];
				`FCR_OFF_PRESCALE1: rdByte = prescaleQ[1];
				`FCR_OFF_DUTY1: rdByte = dutyQ[1];
				`FCR_OFF_THRESH0: rdByte = threshQ[0];
				`FCR_OFF_SPEED0: rdByte = mon0Speed;
				`FCR_OFF_CTRL0: rdByte = {ctrlQ[0][7:4], mon0Status};
				`FCR_OFF_THRESH1: rdByte = threshQ[1];
				`FCR_OFF_SPEED1: rdByte = mon1Speed;
				`FCR_OFF_CTRL1: rdByte = {ctrlQ[1][7:4], mon1Status};
				default: rdByte = 8'h00;
			endcase
		end
	end

	// Read channel: data registered at the address handshake
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			arReadyQ <= 1'b1;
			rValidQ <= 1'b0;
			rDataQ <= 32'h00000000;
			rRespQ <= `FCR_RESP_OKAY;
		end else begin
			if (arReadyQ && s_axi_arvalid) begin
				arReadyQ <= 1'b0;
				rValidQ <= 1'b1;
				rDataQ <= {24'h000000, rdByte};
				rRespQ <= rdOk ? `FCR_RESP_OKAY : `FCR_RESP_DECERR;
			end
			if (rValidQ && s_axi_rready) begin
				rValidQ <= 1'b0;
				arReadyQ <= 1'b1;
			end
		end
	end

	// Port drive, all from flip-flops
	assign s_axi_awready = awReadyQ;
	assign s_axi_wready = wReadyQ;
	assign s_axi_bvalid = bValidQ;
	assign s_axi_bresp = bRespQ;
	assign s_axi_arready = arReadyQ;
	assign s_axi_rvalid = rValidQ;
	assign s_axi_rdata = rDataQ;
	assign s_axi_rresp = rRespQ;

	// Runtime settings to the fan units
	assign fan0Prescale = prescaleQ[0];
	assign fan0Duty = dutyQ[0];
	assign fan1Prescale = prescaleQ[1];
	assign fan1Duty = dutyQ[1];
	assign mon0Threshold = threshQ[0];
	assign mon1Threshold = threshQ[1];
	assign mon0Control = ctrlQ[0][7:4];
	assign mon1Control = ctrlQ[1][7:4];

	// Unit enables from the fan configuration byte
	assign mon0Enable = fanCfgQ[`FCR_CFG_MON0];
	assign mon1Enable = fanCfgQ[`FCR_CFG_MON1];
	assign ctl0Enable = fanCfgQ[`FCR_CFG_CTL0];
	assign ctl1Enable = fanCfgQ[`FCR_CFG_CTL1];
	assign inv0Enable = fanCfgQ[`FCR_CFG_INV0];
	assign inv1Enable = fanCfgQ[`FCR_CFG_INV1];

	// Configuration state
	assign deviceActive = activeQ;
	assign irqSelect = irqSelQ;
	assign irqKindBit = irqKindQ[1];
	assign pinsFloat = pinsFloatQ;

endmodule // fcr_fan_config_regs

// ===== fcr_regs_assertions.sv
// Concurrent checks on the fan control register bank ports
`timescale 1ns/1ps
`include "fcr_defs.vh"
module fcr_regs_checker (
	input wire clock,
	input wire arst_n,
	input wire [`FCR_ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire [7:0] irqSelect,
	input wire irqKindBit,
	input wire deviceActive,
	input wire pinsFloat
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	// Read request accepted at this edge and its address
	wire arTake = s_axi_arvalid && s_axi_arready;
	wire [19:0] rAddr = s_axi_araddr;
	a_dma_fixed: assert property (arTake && rAddr[19:3] == 17'h0003A |=> s_axi_rdata == 32'h4)
		else $error("no-dma report wrong");
	a_kind_read: assert property (arTake && rAddr == 20'h001C4 |=>
		s_axi_rdata == {30'h0, $past(irqKindBit), 1'b1}) else $error("interrupt kind wrong");
	a_base_low: assert property (arTake && rAddr == 20'h00184 |=> s_axi_rdata[3:0] == 4'h0)
		else $error("base low nibble not zero");
	a_sel_read: assert property (arTake && rAddr == 20'h001C0 |=>
		s_axi_rdata == {24'h0, $past(irqSelect)}) else $error("interrupt select wrong");
	a_act_read: assert property (arTake && rAddr == 20'h000C0 |=>
		s_axi_rdata == {31'h0, $past(deviceActive)}) else $error("activate readback wrong");
	a_idle_block: assert property (arTake && rAddr[19:18] == `FCR_SPACE_IO && !deviceActive |=>
		s_axi_rvalid && s_axi_rresp == `FCR_RESP_DECERR && s_axi_rdata == 32'h0)
		else $error("inactive runtime read not refused");
	a_float_cause: assert property (pinsFloat |-> !$past(deviceActive))
		else $error("float while active");
	a_float_clear: assert property (deviceActive |=> !pinsFloat)
		else $error("float not cleared");
	cover property (pinsFloat);
	cover property (s_axi_rvalid && s_axi_rresp == `FCR_RESP_DECERR);
	cover property (arTake && rAddr == 20'h003C0);
endmodule // fcr_regs_checker

// ===== tb_top.sv
// Self-checking bench for the fan control register bank
`timescale 1ns/1ps
`include "fcr_defs.vh"
module tb_top;
	reg clock = 1'b0;
	reg arst_n = 1'b0;
	reg [19:0] s_axi_awaddr = 20'h0, s_axi_araddr = 20'h0;
	reg [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	reg [31:0] s_axi_wdata = 32'h0;
	reg [3:0] s_axi_wstrb = 4'hF, mon0Status = 4'h9, mon1Status = 4'h6;
	reg [7:0] mon0Speed = 8'hA5, mon1Speed = 8'h5A;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [7:0] fan0Prescale, fan0Duty, fan1Prescale, fan1Duty, mon0Threshold, mon1Threshold;
	wire [7:0] irqSelect;
	wire [3:0] mon0Control, mon1Control;
	wire mon0Enable, mon1Enable, ctl0Enable, ctl1Enable, inv0Enable, inv1Enable;
	wire deviceActive, irqKindBit, pinsFloat;
	integer n_errors = 0, checked = 0, cycles = 0, i;
	fcr_fan_config_regs i_dut (.clock(clock), .arst_n(arst_n),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .mon0Speed(mon0Speed), .mon1Speed(mon1Speed),
		.mon0Status(mon0Status), .mon1Status(mon1Status),
		.fan0Prescale(fan0Prescale), .fan0Duty(fan0Duty),
		.fan1Prescale(fan1Prescale), .fan1Duty(fan1Duty),
		.mon0Threshold(mon0Threshold), .mon1Threshold(mon1Threshold),
		.mon0Control(mon0Control), .mon1Control(mon1Control),
		.mon0Enable(mon0Enable), .mon1Enable(mon1Enable),
		.ctl0Enable(ctl0Enable), .ctl1Enable(ctl1Enable),
		.inv0Enable(inv0Enable), .inv1Enable(inv1Enable),
		.deviceActive(deviceActive), .irqSelect(irqSelect),
		.irqKindBit(irqKindBit), .pinsFloat(pinsFloat));
	// Free-running clock
	always #5 clock = ~clock;
	task chk(input [31:0] got, input [31:0] exp);
		checked = checked + 1;
		if (got !== exp) begin
			n_errors = n_errors + 1;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function [19:0] cfg(input [7:0] idx);
		cfg = {10'h000, idx, 2'h0};
	endfunction
	function [19:0] io(input [15:0] a);
		io = {2'h1, a, 2'h0};
	endfunction
	// Expected runtime readback after the pattern {o, ~o} was written everywhere
	function [7:0] rtExp(input [3:0] o);
		case (o)
			4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h9: rtExp = {o, ~o};
			4'h7: rtExp = mon0Speed;
			4'hA: rtExp = mon1Speed;
			4'h8: rtExp = {o, mon0Status};
			4'hB: rtExp = {o, mon1Status};
			default: rtExp = 8'h00;
		endcase
	endfunction
	task wr(input [19:0] a, input [7:0] d, input [1:0] er);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk({30'h0, s_axi_bresp}, {30'h0, er});
	endtask
	task rd(input [19:0] a, input [7:0] ed, input [1:0] er);
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk({30'h0, s_axi_rresp}, {30'h0, er});
		chk(s_axi_rdata, {24'h000000, ed});
	endtask
	task do_reset;
		@(posedge clock);
		arst_n <= 1'b0;
		repeat (16) @(posedge clock);
		arst_n <= 1'b1;
	endtask
	// Configuration space after a hardware reset
	task check_defaults;
		rd(cfg(`FCR_IDX_ACTIVATE), 8'h00, 2'h0);
		rd(cfg(`FCR_IDX_BASE_HI), 8'h00, 2'h0);
		rd(cfg(`FCR_IDX_BASE_LO), 8'h00, 2'h0);
		rd(cfg(`FCR_IDX_IRQ_SEL), 8'h00, 2'h0);
		rd(cfg(`FCR_IDX_IRQ_KIND), 8'h03, 2'h0);
		rd(cfg(`FCR_IDX_DMA_A), 8'h04, 2'h0);
		rd(cfg(`FCR_IDX_DMA_B), 8'h04, 2'h0);
		rd(cfg(`FCR_IDX_FAN_CFG), 8'h00, 2'h0);
	endtask
	task close_out;
		if (n_errors == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Hang guard
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_errors = n_errors + 1;
			close_out;
		end
	end
	// Main sequence
	initial begin
		do_reset;
		check_defaults;
		wr(cfg(`FCR_IDX_BASE_HI), 8'h12, 2'h0);
		wr(cfg(`FCR_IDX_BASE_LO), 8'h3F, 2'h0);
		rd(cfg(`FCR_IDX_BASE_LO), 8'h30, 2'h0);
		rd(cfg(`FCR_IDX_BASE_HI), 8'h12, 2'h0);
		rd(io(16'h1230), 8'h00, 2'h3);
		wr(io(16'h1230), 8'h55, 2'h3);
		wr(cfg(`FCR_IDX_ACTIVATE), 8'hFF, 2'h0);
		rd(cfg(`FCR_IDX_ACTIVATE), 8'h01, 2'h0);
		chk({31'h0, deviceActive}, 32'h1);
		rd(io(16'h1230), 8'h00, 2'h0);
		for (i = 0; i < 16; i = i + 1) wr(io({12'h123, i[3:0]}), {i[3:0], ~i[3:0]}, 2'h0);
		for (i = 0; i < 16; i = i + 1) rd(io({12'h123, i[3:0]}), rtExp(i[3:0]), 2'h0);
		chk({fan0Prescale, fan0Duty, fan1Prescale, fan1Duty}, 32'h0F1E2D3C);
		chk({8'h0, mon0Threshold, mon1Threshold, mon0Control, mon1Control}, 32'h0069968B);
		rd(io(16'h1240), 8'h00, 2'h3);
		rd(20'h80000, 8'h00, 2'h3);
		wr(cfg(`FCR_IDX_IRQ_KIND), 8'h00, 2'h0);
		rd(cfg(`FCR_IDX_IRQ_KIND), 8'h01, 2'h0);
		chk({31'h0, irqKindBit}, 32'h0);
		wr(cfg(`FCR_IDX_IRQ_SEL), 8'h5F, 2'h0);
		s_axi_wstrb <= 4'h0;
		wr(cfg(`FCR_IDX_IRQ_SEL), 8'hAA, 2'h0);
		s_axi_wstrb <= 4'hF;
		rd(cfg(`FCR_IDX_IRQ_SEL), 8'h5F, 2'h0);
		chk({24'h0, irqSelect}, 32'h5F);
		wr(cfg(`FCR_IDX_DMA_A), 8'h00, 2'h0);
		rd(cfg(`FCR_IDX_DMA_A), 8'h04, 2'h0);
		wr(cfg(`FCR_IDX_FAN_CFG), 8'hAA, 2'h0);
		rd(cfg(`FCR_IDX_FAN_CFG), 8'hA8, 2'h0);
		chk({inv1Enable, ctl1Enable, mon1Enable, inv0Enable, ctl0Enable, mon0Enable}, 32'h2A);
		wr(cfg(`FCR_IDX_FAN_CFG), 8'hFF, 2'h0);
		rd(cfg(`FCR_IDX_FAN_CFG), 8'hFD, 2'h0);
		chk({inv1Enable, ctl1Enable, mon1Enable, inv0Enable, ctl0Enable, mon0Enable}, 32'h3F);
		chk({31'h0, pinsFloat}, 32'h0);
		wr(cfg(`FCR_IDX_ACTIVATE), 8'h00, 2'h0);
		@(posedge clock);
		#1;
		chk({31'h0, pinsFloat}, 32'h1);
		chk({31'h0, deviceActive}, 32'h0);
		rd(io(16'h1230), 8'h00, 2'h3);
		wr(cfg(`FCR_IDX_FAN_CFG), 8'h00, 2'h0);
		@(posedge clock);
		#1;
		chk({31'h0, pinsFloat}, 32'h0);
		do_reset;
		check_defaults;
		close_out;
	end
endmodule // tb_top
bind fcr_fan_config_regs fcr_regs_checker i_chk (.clock(clock), .arst_n(arst_n),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.irqSelect(irqSelect), .irqKindBit(irqKindBit), .deviceActive(deviceActive),
	.pinsFloat(pinsFloat));
